// ### rtl/lsx_pkg.sv
// Constants and types shared by the load/store execution unit
package lsx_pkg;

  localparam int          REG_COUNT   = 32;
  localparam int          REG_IDX_W   = 5;
  localparam int          DATA_W      = 8;
  localparam int          ADDR_W      = 16;
  localparam int          DISP_W      = 6;
  localparam int          PMEM_ADDR_W = 15;

  // Pointer pairs live in the register file, low byte first
  localparam logic [4:0]  PTR_X_LO    = 5'h1a;
  localparam logic [4:0]  PTR_Y_LO    = 5'h1c;
  localparam logic [4:0]  PTR_Z_LO    = 5'h1e;
  localparam logic [4:0]  PTR_HI_OFS  = 5'h01;
  localparam logic [4:0]  REG_ZERO    = 5'h00;

  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [15:0] STACK_RESET = 16'h00ff;
  localparam logic [15:0] ADDR_STEP   = 16'h0001;

  // Occupancy in clock cycles, accept cycle included
  localparam int          DATA_CYCLES = 2;
  localparam int          PMEM_CYCLES = 3;

  typedef enum logic [3:0] {
    LSX_OP_INDIRECT_LOAD,
    LSX_OP_OFFSET_LOAD,
    LSX_OP_ABSOLUTE_LOAD,
    LSX_OP_INDIRECT_STORE,
    LSX_OP_OFFSET_STORE,
    LSX_OP_ABSOLUTE_STORE,
    LSX_OP_PROGRAM_MEMORY_READ,
    LSX_OP_PUSH,
    LSX_OP_POP
  } lsx_op_e;

  typedef enum logic [1:0] {
    LSX_PTR_X,
    LSX_PTR_Y,
    LSX_PTR_Z
  } lsx_ptr_e;

  typedef enum logic [1:0] {
    LSX_MODE_PLAIN,
    LSX_MODE_POST_INC,
    LSX_MODE_PRE_DEC
  } lsx_mode_e;

  typedef enum logic [1:0] {
    LSX_STATE_IDLE,
    LSX_STATE_ACCESS,
    LSX_STATE_PWAIT
  } lsx_state_e;

endpackage : lsx_pkg

// ### rtl/lsx_addr_gen.sv
// Effective address and pointer update for indirect accesses
`timescale 1ns/100ps
`default_nettype none
module lsx_addr_gen (
  input  wire logic [15:0]      ptrValue,
  input  wire lsx_pkg::lsx_mode_e mode,
  input  wire logic             useDisp,
  input  wire logic [5:0]       disp,
  output logic      [15:0]      accessAddr,
  output logic      [15:0]      ptrNext,
  output logic                  ptrWrite
);

  always_comb begin
    accessAddr = ptrValue;
    ptrNext    = ptrValue;
    ptrWrite   = 1'b0;
    if (useDisp) begin
      // Displacement never touches the pointer
      accessAddr = ptrValue + {10'h000, disp};
    end else begin
      case (mode)
        lsx_pkg::LSX_MODE_POST_INC: begin
          ptrNext  = ptrValue + lsx_pkg::ADDR_STEP;
          ptrWrite = 1'b1;
        end
        lsx_pkg::LSX_MODE_PRE_DEC: begin
          // Decrement first, access the new address
          accessAddr = ptrValue - lsx_pkg::ADDR_STEP;
          ptrNext    = ptrValue - lsx_pkg::ADDR_STEP;
          ptrWrite   = 1'b1;
        end
        default: begin
          ptrWrite = 1'b0;
        end
      endcase
    end
  end

endmodule : lsx_addr_gen
`default_nettype wire

// ### rtl/lsx_exec.sv
// Load/store execution unit with register file, stack pointer and memory ports
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Indirect load reads pointer address; optional post-increment
// - Pre-decrement load: decrement pointer, then read
// - Offset load reads Y or Z pointer plus displacement, pointer kept
// - Absolute load reads instruction address, two cycles
// - Post-increment store writes, then advances pointer
// - Pre-decrement store: decrement pointer, then write
// - Offset store writes Y or Z pointer plus displacement
// - Absolute store writes instruction address, two cycles
// - Program memory read via Z, three cycles
// - Push writes source register to stack, two cycles
// - Pop moves stack top to destination, two cycles
module lsx_exec (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 cmdValid,
  output logic                      cmdReady,
  input  wire lsx_pkg::lsx_op_e     cmdOp,
  input  wire lsx_pkg::lsx_ptr_e    cmdPtr,
  input  wire lsx_pkg::lsx_mode_e   cmdMode,
  input  wire logic [4:0]           cmdReg,
  input  wire logic [5:0]           cmdDisp,
  input  wire logic [15:0]          cmdAddr,
  output logic                      opDone,
  output logic [15:0]               dmemAddr,
  output logic                      dmemRdEn,
  output logic                      dmemWrEn,
  output logic [7:0]                dmemWrData,
  input  wire logic [7:0]           dmemRdData,
  output logic [14:0]               pmemAddr,
  output logic                      pmemRdEn,
  input  wire logic [15:0]          pmemRdData,
  output logic [15:0]               stackPointer,
  input  wire logic [4:0]           viewRegIdx,
  output logic [7:0]                viewRegData
);

  lsx_pkg::lsx_state_e state_q, state_d;
  logic [7:0]          regFile_q [lsx_pkg::REG_COUNT];
  logic [7:0]          regFile_d [lsx_pkg::REG_COUNT];
  logic [15:0]         sp_q, sp_d;
  logic [15:0]         dmemAddr_q, dmemAddr_d;
  logic                dmemRdEn_q, dmemRdEn_d;
  logic                dmemWrEn_q, dmemWrEn_d;
  logic [7:0]          dmemWrData_q, dmemWrData_d;
  logic [14:0]         pmemAddr_q, pmemAddr_d;
  logic                pmemRdEn_q, pmemRdEn_d;
  logic                highByte_q, highByte_d;
  logic [4:0]          dest_q, dest_d;
  logic                loadPend_q, loadPend_d;
  logic                done_q, done_d;

  logic                cmdAccept;
  logic [4:0]          ptrLo;
  logic [15:0]         ptrValue;
  logic [15:0]         zValue;
  logic                useDisp;
  logic [15:0]         genAddr;
  logic [15:0]         genNext;
  logic                genWrite;

  assign cmdAccept = cmdValid && (state_q == lsx_pkg::LSX_STATE_IDLE);
  assign cmdReady  = (state_q == lsx_pkg::LSX_STATE_IDLE);

  always_comb begin
    case (cmdPtr)
      lsx_pkg::LSX_PTR_X: ptrLo = lsx_pkg::PTR_X_LO;
      lsx_pkg::LSX_PTR_Y: ptrLo = lsx_pkg::PTR_Y_LO;
      default:            ptrLo = lsx_pkg::PTR_Z_LO;
    endcase
  end

  assign ptrValue = {regFile_q[ptrLo + lsx_pkg::PTR_HI_OFS], regFile_q[ptrLo]};
  assign zValue   = {regFile_q[lsx_pkg::PTR_Z_LO + lsx_pkg::PTR_HI_OFS], regFile_q[lsx_pkg::PTR_Z_LO]};
  assign useDisp  = (cmdOp == lsx_pkg::LSX_OP_OFFSET_LOAD) || (cmdOp == lsx_pkg::LSX_OP_OFFSET_STORE);

  lsx_addr_gen lsx_addr_gen_i (
    .ptrValue   (ptrValue),
    .mode       (cmdMode),
    .useDisp    (useDisp),
    .disp       (cmdDisp),
    .accessAddr (genAddr),
    .ptrNext    (genNext),
    .ptrWrite   (genWrite)
  );

  always_comb begin
    state_d      = state_q;
    regFile_d    = regFile_q;
    sp_d         = sp_q;
    dmemAddr_d   = dmemAddr_q;
    dmemRdEn_d   = 1'b0;
    dmemWrEn_d   = 1'b0;
    dmemWrData_d = dmemWrData_q;
    pmemAddr_d   = pmemAddr_q;
    pmemRdEn_d   = 1'b0;
    highByte_d   = highByte_q;
    dest_d       = dest_q;
    loadPend_d   = 1'b0;
    done_d       = 1'b0;
    case (state_q)
      lsx_pkg::LSX_STATE_IDLE: begin
        if (cmdAccept) begin
          state_d      = lsx_pkg::LSX_STATE_ACCESS;
          dest_d       = cmdReg;
          dmemWrData_d = regFile_q[cmdReg];
          case (cmdOp)
            lsx_pkg::LSX_OP_INDIRECT_LOAD, lsx_pkg::LSX_OP_INDIRECT_STORE: begin
              dmemAddr_d = genAddr;
              dmemRdEn_d = (cmdOp == lsx_pkg::LSX_OP_INDIRECT_LOAD);
              dmemWrEn_d = (cmdOp == lsx_pkg::LSX_OP_INDIRECT_STORE);
              loadPend_d = (cmdOp == lsx_pkg::LSX_OP_INDIRECT_LOAD);
              if (genWrite) begin
                regFile_d[ptrLo]                        = genNext[7:0];
                regFile_d[ptrLo + lsx_pkg::PTR_HI_OFS]  = genNext[15:8];
              end
            end
            lsx_pkg::LSX_OP_OFFSET_LOAD, lsx_pkg::LSX_OP_OFFSET_STORE: begin
              // The X pointer has no displacement form: no access, still completes
              if (cmdPtr != lsx_pkg::LSX_PTR_X) begin
                dmemAddr_d = genAddr;
                dmemRdEn_d = (cmdOp == lsx_pkg::LSX_OP_OFFSET_LOAD);
                dmemWrEn_d = (cmdOp == lsx_pkg::LSX_OP_OFFSET_STORE);
                loadPend_d = (cmdOp == lsx_pkg::LSX_OP_OFFSET_LOAD);
              end
            end
            lsx_pkg::LSX_OP_ABSOLUTE_LOAD: begin
              dmemAddr_d = cmdAddr;
              dmemRdEn_d = 1'b1;
              loadPend_d = 1'b1;
            end
            lsx_pkg::LSX_OP_ABSOLUTE_STORE: begin
              dmemAddr_d = cmdAddr;
              dmemWrEn_d = 1'b1;
            end
            lsx_pkg::LSX_OP_PROGRAM_MEMORY_READ: begin
              pmemAddr_d = zValue[15:1];
              pmemRdEn_d = 1'b1;
              highByte_d = zValue[0];
              if (cmdMode == lsx_pkg::LSX_MODE_POST_INC) begin
                regFile_d[lsx_pkg::PTR_Z_LO]                      = 8'(zValue + lsx_pkg::ADDR_STEP);
                regFile_d[lsx_pkg::PTR_Z_LO + lsx_pkg::PTR_HI_OFS] = 8'((zValue + lsx_pkg::ADDR_STEP) >> 8);
              end
            end
            lsx_pkg::LSX_OP_PUSH: begin
              dmemAddr_d = sp_q;
              dmemWrEn_d = 1'b1;
              sp_d       = sp_q - lsx_pkg::ADDR_STEP;
            end
            lsx_pkg::LSX_OP_POP: begin
              dmemAddr_d = sp_q + lsx_pkg::ADDR_STEP;
              dmemRdEn_d = 1'b1;
              loadPend_d = 1'b1;
              sp_d       = sp_q + lsx_pkg::ADDR_STEP;
            end
            default: begin
              state_d = lsx_pkg::LSX_STATE_ACCESS;
            end
          endcase
        end
      end
      lsx_pkg::LSX_STATE_ACCESS: begin
        if (pmemRdEn_q) begin
          // Program memory answers one cycle later
          state_d = lsx_pkg::LSX_STATE_PWAIT;
        end else begin
          if (loadPend_q) begin
            regFile_d[dest_q] = dmemRdData;
          end
          state_d = lsx_pkg::LSX_STATE_IDLE;
          done_d  = 1'b1;
        end
      end
      lsx_pkg::LSX_STATE_PWAIT: begin
        regFile_d[dest_q] = highByte_q ? pmemRdData[15:8] : pmemRdData[7:0];
        state_d = lsx_pkg::LSX_STATE_IDLE;
        done_d  = 1'b1;
      end
      default: begin
        state_d = lsx_pkg::LSX_STATE_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q      <= lsx_pkg::LSX_STATE_IDLE;
      sp_q         <= lsx_pkg::STACK_RESET;
      dmemAddr_q   <= 16'h0000;
      dmemRdEn_q   <= 1'b0;
      dmemWrEn_q   <= 1'b0;
      dmemWrData_q <= 8'h00;
      pmemAddr_q   <= 15'h0000;
      pmemRdEn_q   <= 1'b0;
      highByte_q   <= 1'b0;
      dest_q       <= 5'h00;
      loadPend_q   <= 1'b0;
      done_q       <= 1'b0;
    end else begin
      state_q      <= state_d;
      sp_q         <= sp_d;
      dmemAddr_q   <= dmemAddr_d;
      dmemRdEn_q   <= dmemRdEn_d;
      dmemWrEn_q   <= dmemWrEn_d;
      dmemWrData_q <= dmemWrData_d;
      pmemAddr_q   <= pmemAddr_d;
      pmemRdEn_q   <= pmemRdEn_d;
      highByte_q   <= highByte_d;
      dest_q       <= dest_d;
      loadPend_q   <= loadPend_d;
      done_q       <= done_d;
    end
  end

  for (genvar gi = 0; gi < lsx_pkg::REG_COUNT; gi++) begin : g_reg
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        regFile_q[gi] <= lsx_pkg::REG_RESET;
      end else begin
        regFile_q[gi] <= regFile_d[gi];
      end
    end
  end

  assign opDone       = done_q;
  assign dmemAddr     = dmemAddr_q;
  assign dmemRdEn     = dmemRdEn_q;
  assign dmemWrEn     = dmemWrEn_q;
  assign dmemWrData   = dmemWrData_q;
  assign pmemAddr     = pmemAddr_q;
  assign pmemRdEn     = pmemRdEn_q;
  assign stackPointer = sp_q;
  assign viewRegData  = regFile_q[viewRegIdx];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_indload_addr: assert property (cmdAccept && cmdOp == lsx_pkg::LSX_OP_INDIRECT_LOAD
      && cmdMode != lsx_pkg::LSX_MODE_PRE_DEC
      |=> dmemRdEn && dmemAddr == $past(ptrValue) ##1 opDone && cmdReady)
    else $error("indirect load address or timing wrong");

  a_predec_load: assert property (cmdAccept && cmdOp == lsx_pkg::LSX_OP_INDIRECT_LOAD
      && cmdMode == lsx_pkg::LSX_MODE_PRE_DEC
      |=> dmemRdEn && dmemAddr == $past(ptrValue) - 16'h0001)
    else $error("pre-decrement load address wrong");

  a_offset_load: assert property (cmdAccept && cmdOp == lsx_pkg::LSX_OP_OFFSET_LOAD
      && cmdPtr != lsx_pkg::LSX_PTR_X
      |=> dmemRdEn && dmemAddr == $past(ptrValue) + {10'h000, $past(cmdDisp)}
          && $stable(regFile_q[lsx_pkg::PTR_Y_LO]) && $stable(regFile_q[lsx_pkg::PTR_Z_LO]))
    else $error("offset load address or pointer wrong");

  a_abs_load: assert property (cmdAccept && cmdOp == lsx_pkg::LSX_OP_ABSOLUTE_LOAD
      |=> dmemRdEn && dmemAddr == $past(cmdAddr) && !cmdReady ##1 opDone)
    else $error("absolute load wrong");

  a_postinc_store: assert property (cmdAccept && cmdOp == lsx_pkg::LSX_OP_INDIRECT_STORE
      && cmdMode == lsx_pkg::LSX_MODE_POST_INC
      |=> dmemWrEn && dmemAddr == $past(ptrValue) && dmemWrData == $past(regFile_q[cmdReg])
          && ptrValue == dmemAddr + 16'h0001 ##1 opDone)
    else $error("post-increment store wrong");

  a_predec_store: assert property (cmdAccept && cmdOp == lsx_pkg::LSX_OP_INDIRECT_STORE
      && cmdMode == lsx_pkg::LSX_MODE_PRE_DEC
      |=> dmemWrEn && dmemAddr == $past(ptrValue) - 16'h0001)
    else $error("pre-decrement store address wrong");

  a_offset_store: assert property (cmdAccept && cmdOp == lsx_pkg::LSX_OP_OFFSET_STORE
      && cmdPtr != lsx_pkg::LSX_PTR_X
      |=> dmemWrEn && dmemAddr == $past(ptrValue) + {10'h000, $past(cmdDisp)})
    else $error("offset store address wrong");

  a_abs_store: assert property (cmdAccept && cmdOp == lsx_pkg::LSX_OP_ABSOLUTE_STORE
      |=> dmemWrEn && dmemAddr == $past(cmdAddr) ##1 cmdReady && opDone)
    else $error("absolute store wrong");

  a_pmem_three: assert property (cmdAccept && cmdOp == lsx_pkg::LSX_OP_PROGRAM_MEMORY_READ
      |=> pmemRdEn && pmemAddr == $past(zValue[15:1]) ##1 !cmdReady ##1 cmdReady && opDone)
    else $error("program memory read timing wrong");

  a_push_stack: assert property (cmdAccept && cmdOp == lsx_pkg::LSX_OP_PUSH
      |=> dmemWrEn && dmemAddr == $past(stackPointer)
          && stackPointer == $past(stackPointer) - 16'h0001 ##1 opDone)
    else $error("push wrong");

  a_pop_stack: assert property (cmdAccept && cmdOp == lsx_pkg::LSX_OP_POP
      |=> dmemRdEn && dmemAddr == $past(stackPointer) + 16'h0001 ##1 opDone)
    else $error("pop wrong");

  a_plain_store: assert property (cmdAccept && cmdOp == lsx_pkg::LSX_OP_INDIRECT_STORE
      && cmdMode == lsx_pkg::LSX_MODE_PLAIN
      |=> dmemWrEn && dmemAddr == $past(ptrValue) && ptrValue == $past(ptrValue) ##1 opDone)
    else $error("plain store wrong");

endmodule : lsx_exec
`default_nettype wire

// ### testbench/lsx_mem_model.sv
// Behavioural data and program memories facing the load/store unit
`timescale 1ns/100ps
`default_nettype none
module lsx_mem_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] dmemAddr,
  input  wire logic        dmemRdEn,
  input  wire logic        dmemWrEn,
  input  wire logic [7:0]  dmemWrData,
  output logic      [7:0]  dmemRdData,
  input  wire logic [14:0] pmemAddr,
  input  wire logic        pmemRdEn,
  output logic      [15:0] pmemRdData
);
  logic [7:0]  dmem [0:511];
  logic [15:0] pmem [0:63];
  logic [7:0]  lastRd_q;
  logic [15:0] pWord_q;
  logic        pValid_q;

  // Idle buses show the inverse of the last value, so a mistimed sample fails
  assign dmemRdData = dmemRdEn ? dmem[dmemAddr[8:0]] : ~lastRd_q;
  assign pmemRdData = pValid_q ? pWord_q : ~pWord_q;

  always @(posedge ref_clk) begin
    if (dmemWrEn) dmem[dmemAddr[8:0]] <= dmemWrData;
    if (dmemRdEn) lastRd_q <= dmem[dmemAddr[8:0]];
    pValid_q <= pmemRdEn;
    if (pmemRdEn) pWord_q <= pmem[pmemAddr[5:0]];
  end
endmodule : lsx_mem_model
`default_nettype wire

// ### testbench/test_load_store_execution.sv
// Self-checking bench for the load/store execution unit
`timescale 1ns/100ps
`default_nettype none
module test_load_store_execution;
  logic ref_clk, rst, cmdValid, cmdReady, opDone, dmemRdEn, dmemWrEn, pmemRdEn;
  lsx_pkg::lsx_op_e   cmdOp;
  lsx_pkg::lsx_ptr_e  cmdPtr;
  lsx_pkg::lsx_mode_e cmdMode;
  logic [4:0]  cmdReg, viewRegIdx;
  logic [5:0]  cmdDisp;
  logic [15:0] cmdAddr, dmemAddr, pmemRdData, stackPointer;
  logic [7:0]  dmemWrData, dmemRdData, viewRegData;
  logic [14:0] pmemAddr;
  int          num_errors, total_checks;

  lsx_exec lsx_exec_i (.ref_clk(ref_clk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
    .cmdPtr(cmdPtr), .cmdMode(cmdMode), .cmdReg(cmdReg), .cmdDisp(cmdDisp), .cmdAddr(cmdAddr), .opDone(opDone),
    .dmemAddr(dmemAddr), .dmemRdEn(dmemRdEn), .dmemWrEn(dmemWrEn), .dmemWrData(dmemWrData),
    .dmemRdData(dmemRdData), .pmemAddr(pmemAddr), .pmemRdEn(pmemRdEn), .pmemRdData(pmemRdData),
    .stackPointer(stackPointer), .viewRegIdx(viewRegIdx), .viewRegData(viewRegData));
  lsx_mem_model lsx_mem_model_i (.ref_clk(ref_clk), .dmemAddr(dmemAddr), .dmemRdEn(dmemRdEn),
    .dmemWrEn(dmemWrEn), .dmemWrData(dmemWrData), .dmemRdData(dmemRdData), .pmemAddr(pmemAddr),
    .pmemRdEn(pmemRdEn), .pmemRdData(pmemRdData));

  always #2 ref_clk = ~ref_clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Returns one ns after the edge where opDone is seen, ready for the next command
  task automatic cmd(input lsx_pkg::lsx_op_e op, input lsx_pkg::lsx_ptr_e ptr, input lsx_pkg::lsx_mode_e mode,
                     input logic [4:0] r, input logic [5:0] d, input logic [15:0] a, input int cyc);
    int n;
    n = 0;
    while (cmdReady !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 20) begin
        num_errors++;
        $display("wrong value at %0t: command never taken", $time);
        end_of_test();
      end
    end
    cmdValid = 1'b1;
    cmdOp = op;
    cmdPtr = ptr;
    cmdMode = mode;
    cmdReg = r;
    cmdDisp = d;
    cmdAddr = a;
    @(posedge ref_clk);
    #1;
    cmdValid = 1'b0;
    n = 1;
    while (opDone !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 20) begin
        num_errors++;
        $display("wrong value at %0t: command never completed", $time);
        end_of_test();
      end
    end
    chk(16'(n), 16'(cyc), "cycle count");
  endtask : cmd

  task automatic chk_reg(input logic [4:0] i, input logic [7:0] exp, input string what);
    viewRegIdx = i;
    @(posedge ref_clk);
    #1;
    chk({8'h00, viewRegData}, {8'h00, exp}, what);
  endtask : chk_reg

  task automatic chk_ptr(input logic [4:0] lo, input logic [15:0] exp);
    chk_reg(lo, exp[7:0], "pointer low");
    chk_reg(lo + 5'h01, exp[15:8], "pointer high");
  endtask : chk_ptr

  task automatic chk_mem(input logic [8:0] a, input logic [7:0] exp);
    chk({8'h00, lsx_mem_model_i.dmem[a]}, {8'h00, exp}, "data memory");
  endtask : chk_mem

  task automatic ld_abs(input logic [4:0] i, input logic [7:0] v);
    lsx_mem_model_i.dmem[9'h1e0 + {4'h0, i}] = v;
    cmd(lsx_pkg::LSX_OP_ABSOLUTE_LOAD, lsx_pkg::LSX_PTR_X, lsx_pkg::LSX_MODE_PLAIN, i, 6'h00,
        16'h01e0 + {11'h000, i}, lsx_pkg::DATA_CYCLES);
    chk_reg(i, v, "absolute load");
  endtask : ld_abs

  task automatic set_ptr(input logic [4:0] lo, input logic [15:0] v);
    ld_abs(lo, v[7:0]);
    ld_abs(lo + 5'h01, v[15:8]);
  endtask : set_ptr

  task automatic acc(input lsx_pkg::lsx_op_e op, input lsx_pkg::lsx_ptr_e p, input lsx_pkg::lsx_mode_e m,
                     input logic [4:0] r);
    cmd(op, p, m, r, 6'h00, 16'h0000, lsx_pkg::DATA_CYCLES);
  endtask : acc

  task automatic test_absolute();
    ld_abs(5'h05, 8'h3c);
    cmd(lsx_pkg::LSX_OP_ABSOLUTE_STORE, lsx_pkg::LSX_PTR_X, lsx_pkg::LSX_MODE_PLAIN, 5'h05, 6'h00, 16'h0040,
        lsx_pkg::DATA_CYCLES);
    chk_mem(9'h040, 8'h3c);
    $display("test absolute done");
  endtask : test_absolute

  task automatic test_indirect_load();
    lsx_mem_model_i.dmem[9'h0ff] = 8'ha1;
    lsx_mem_model_i.dmem[9'h100] = 8'ha2;
    set_ptr(lsx_pkg::PTR_X_LO, 16'h00ff);
    acc(lsx_pkg::LSX_OP_INDIRECT_LOAD, lsx_pkg::LSX_PTR_X, lsx_pkg::LSX_MODE_PLAIN, 5'h01);
    chk_reg(5'h01, 8'ha1, "plain load");
    chk_ptr(lsx_pkg::PTR_X_LO, 16'h00ff);
    acc(lsx_pkg::LSX_OP_INDIRECT_LOAD, lsx_pkg::LSX_PTR_X, lsx_pkg::LSX_MODE_POST_INC, 5'h02);
    chk_reg(5'h02, 8'ha1, "post-inc load");
    chk_ptr(lsx_pkg::PTR_X_LO, 16'h0100);
    acc(lsx_pkg::LSX_OP_INDIRECT_LOAD, lsx_pkg::LSX_PTR_X, lsx_pkg::LSX_MODE_PLAIN, 5'h02);
    chk_reg(5'h02, 8'ha2, "load after carry");
    acc(lsx_pkg::LSX_OP_INDIRECT_LOAD, lsx_pkg::LSX_PTR_X, lsx_pkg::LSX_MODE_PRE_DEC, 5'h03);
    chk_reg(5'h03, 8'ha1, "pre-dec load");
    chk_ptr(lsx_pkg::PTR_X_LO, 16'h00ff);
    $display("test indirect load done");
  endtask : test_indirect_load

  task automatic test_indirect_store();
    set_ptr(lsx_pkg::PTR_Z_LO, 16'h0060);
    acc(lsx_pkg::LSX_OP_INDIRECT_STORE, lsx_pkg::LSX_PTR_Z, lsx_pkg::LSX_MODE_PLAIN, 5'h05);
    chk_mem(9'h060, 8'h3c);
    chk_ptr(lsx_pkg::PTR_Z_LO, 16'h0060);
    acc(lsx_pkg::LSX_OP_INDIRECT_STORE, lsx_pkg::LSX_PTR_Z, lsx_pkg::LSX_MODE_POST_INC, 5'h01);
    chk_mem(9'h060, 8'ha1);
    chk_ptr(lsx_pkg::PTR_Z_LO, 16'h0061);
    acc(lsx_pkg::LSX_OP_INDIRECT_STORE, lsx_pkg::LSX_PTR_Z, lsx_pkg::LSX_MODE_PRE_DEC, 5'h02);
    chk_mem(9'h060, 8'ha2);
    chk_ptr(lsx_pkg::PTR_Z_LO, 16'h0060);
    $display("test indirect store done");
  endtask : test_indirect_store

  task automatic test_offset();
    lsx_mem_model_i.dmem[9'h0af] = 8'h5e;
    set_ptr(lsx_pkg::PTR_Y_LO, 16'h0070);
    // Largest displacement catches a truncated or sign-extended field
    cmd(lsx_pkg::LSX_OP_OFFSET_LOAD, lsx_pkg::LSX_PTR_Y, lsx_pkg::LSX_MODE_PLAIN, 5'h06, 6'h3f, 16'h0000,
        lsx_pkg::DATA_CYCLES);
    chk_reg(5'h06, 8'h5e, "offset load");
    cmd(lsx_pkg::LSX_OP_OFFSET_STORE, lsx_pkg::LSX_PTR_Y, lsx_pkg::LSX_MODE_PLAIN, 5'h06, 6'h01, 16'h0000,
        lsx_pkg::DATA_CYCLES);
    chk_mem(9'h071, 8'h5e);
    chk_ptr(lsx_pkg::PTR_Y_LO, 16'h0070);
    // X has no displacement form: both complete without any memory or register effect
    lsx_mem_model_i.dmem[9'h101] = 8'h77;
    cmd(lsx_pkg::LSX_OP_OFFSET_STORE, lsx_pkg::LSX_PTR_X, lsx_pkg::LSX_MODE_PLAIN, 5'h05, 6'h02, 16'h0000,
        lsx_pkg::DATA_CYCLES);
    chk_mem(9'h101, 8'h77);
    cmd(lsx_pkg::LSX_OP_OFFSET_LOAD, lsx_pkg::LSX_PTR_X, lsx_pkg::LSX_MODE_PLAIN, 5'h06, 6'h02, 16'h0000,
        lsx_pkg::DATA_CYCLES);
    chk_reg(5'h06, 8'h5e, "offset load through X");
    $display("test offset done");
  endtask : test_offset

  task automatic test_program_read();
    lsx_mem_model_i.pmem[2] = 16'hc3d4;
    lsx_mem_model_i.pmem[3] = 16'h9a8b;
    set_ptr(lsx_pkg::PTR_Z_LO, 16'h0005);
    cmd(lsx_pkg::LSX_OP_PROGRAM_MEMORY_READ, lsx_pkg::LSX_PTR_Z, lsx_pkg::LSX_MODE_PLAIN, lsx_pkg::REG_ZERO,
        6'h00, 16'h0000, lsx_pkg::PMEM_CYCLES);
    chk_reg(lsx_pkg::REG_ZERO, 8'hc3, "program read high byte");
    cmd(lsx_pkg::LSX_OP_PROGRAM_MEMORY_READ, lsx_pkg::LSX_PTR_Z, lsx_pkg::LSX_MODE_POST_INC, 5'h07, 6'h00,
        16'h0000, lsx_pkg::PMEM_CYCLES);
    chk_reg(5'h07, 8'hc3, "program read post-inc");
    chk_ptr(lsx_pkg::PTR_Z_LO, 16'h0006);
    cmd(lsx_pkg::LSX_OP_PROGRAM_MEMORY_READ, lsx_pkg::LSX_PTR_Z, lsx_pkg::LSX_MODE_PLAIN, 5'h08, 6'h00,
        16'h0000, lsx_pkg::PMEM_CYCLES);
    chk_reg(5'h08, 8'h8b, "program read low byte");
    $display("test program read done");
  endtask : test_program_read

  task automatic test_stack();
    chk(stackPointer, lsx_pkg::STACK_RESET, "stack reset");
    acc(lsx_pkg::LSX_OP_PUSH, lsx_pkg::LSX_PTR_X, lsx_pkg::LSX_MODE_PLAIN, 5'h05);
    acc(lsx_pkg::LSX_OP_PUSH, lsx_pkg::LSX_PTR_X, lsx_pkg::LSX_MODE_PLAIN, 5'h06);
    chk_mem(9'h0ff, 8'h3c);
    chk_mem(9'h0fe, 8'h5e);
    chk(stackPointer, 16'h00fd, "stack after push");
    acc(lsx_pkg::LSX_OP_POP, lsx_pkg::LSX_PTR_X, lsx_pkg::LSX_MODE_PLAIN, 5'h09);
    acc(lsx_pkg::LSX_OP_POP, lsx_pkg::LSX_PTR_X, lsx_pkg::LSX_MODE_PLAIN, 5'h0a);
    chk_reg(5'h09, 8'h5e, "first pop");
    chk_reg(5'h0a, 8'h3c, "second pop");
    chk(stackPointer, lsx_pkg::STACK_RESET, "stack after pop");
    $display("test stack done");
  endtask : test_stack

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdOp = lsx_pkg::LSX_OP_INDIRECT_LOAD;
    cmdPtr = lsx_pkg::LSX_PTR_X;
    cmdMode = lsx_pkg::LSX_MODE_PLAIN;
    cmdReg = 5'h00;
    cmdDisp = 6'h00;
    cmdAddr = 16'h0000;
    viewRegIdx = 5'h00;
    num_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    test_absolute();
    test_indirect_load();
    test_indirect_store();
    test_offset();
    test_program_read();
    test_stack();
    end_of_test();
  end
endmodule : test_load_store_execution
`default_nettype wire
